/* File: ufo_ctrl.sv */
/*
 * Upstream port failover controller: status, control, watchdog and
 * interrupt registers on a classic Wishbone slave, plus the failover
 * sequencer. Assumes straps are stable around the release of rstn and
 * that the select pin is already synchronous to clk.
 */
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ufo_defines.svh"

module ufo_ctrl import ufo_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic strap_failover_mode,
	input wire logic strap_upstream_port,
	input wire logic strap_signal_enable,
	input wire logic strap_timer_enable,
	input wire logic gpio_pin_in,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	output logic upstream_port_o,
	output logic failover_busy_o
);

	// ****************************************************
	// Functions
	// ****************************************************

	// Word match, byte lanes ignored
	function automatic logic hit(input logic [11:0] adr,
		input logic [11:0] off);
		hit = (adr[11:2] == off[11:2]);
	endfunction

	// Byte-enable merge of a write into a word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = dat[i*8 +: 8];
			end
		end
		merge = res;
	endfunction

	// ****************************************************
	// State
	// ****************************************************
	logic init_done_r;
	logic mode_r;
	logic cur_port_r;
	ufo_ctl_t ctl_r;
	ufo_ctl_t ctl_nxt;
	logic done_flag_r;
	logic started_flag_r;
	logic [31:0] wdog_r;
	logic [31:0] wdog_nxt;
	logic [7:0] tick_cnt_r;
	logic tick_r;
	ufo_state_t state_r;
	logic [7:0] swap_cnt_r;
	logic target_r;
	logic alt_en_r;
	ufo_evt_t irq_sts_r;
	ufo_evt_t irq_en_r;
	ufo_evt_t irq_sts_nxt;
	logic ack_r;
	logic [31:0] rdat_r;
	logic [31:0] rdat;

	// ****************************************************
	// Bus decode
	// ****************************************************
	wire req = wb_cyc_i & wb_stb_i & ~ack_r;
	wire wr = req & wb_we_i;
	wire wr_sts = wr & hit(wb_adr_i, `UFO_OFF_STATUS) & wb_sel_i[0];
	wire wr_ctl = wr & hit(wb_adr_i, `UFO_OFF_CONTROL) & wb_sel_i[0];
	wire wr_wdog = wr & hit(wb_adr_i, `UFO_OFF_WDOG);
	wire wr_ien = wr & hit(wb_adr_i, `UFO_OFF_IRQ_EN) & wb_sel_i[0];
	wire wr_iclr = wr & hit(wb_adr_i, `UFO_OFF_IRQ_CLR) & wb_sel_i[0];
	wire wr_pin = wr & hit(wb_adr_i, `UFO_OFF_PIN_CFG) & wb_sel_i[0];

	// ****************************************************
	// Microsecond tick and watchdog
	// ****************************************************
	wire tick_wrap = (tick_cnt_r == 8'(`UFO_TICK_CYC - 1));
	// A bus write wins over the decrement in the same cycle
	assign wdog_nxt = wr_wdog ? merge(wdog_r, wb_dat_i, wb_sel_i) :
		(tick_r && wdog_r != 32'h0000_0000) ? wdog_r - 32'h0000_0001 :
		wdog_r;
	// Only the one-to-zero step counts, not sitting at zero
	wire wdog_fire = tick_r & ~wr_wdog & (wdog_r == 32'h0000_0001);

	// Divider for the 1 us enable pulse
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_r <= 8'h00;
			tick_r <= 1'b0;
		end else begin
			tick_cnt_r <= tick_wrap ? 8'h00 : tick_cnt_r + 8'h01;
			tick_r <= tick_wrap;
		end
	end

	// Watchdog count, steps down once per tick and holds at zero until written
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wdog_r <= `UFO_WDOG_RST;
		end else begin
			wdog_r <= wdog_nxt;
		end
	end

	// ****************************************************
	// Failover start sources
	// ****************************************************
	wire idle = (state_r == UFO_ST_IDLE);
	wire live = mode_r & init_done_r & idle;
	// Pin only counts when routed to its alternate function
	wire pin_sel = alt_en_r & gpio_pin_in;
	wire sw_start = live & wr_ctl &
		(wb_dat_i[`UFO_CTL_SELECT] != cur_port_r);
	wire sig_start = live & ctl_r.sig_en & alt_en_r &
		(pin_sel != cur_port_r);
	wire tim_start = live & ctl_r.tim_en & wdog_fire;
	wire start = sw_start | sig_start | tim_start;
	// Software first, then pin, then timer which toggles the port
	wire start_target = sw_start ? wb_dat_i[`UFO_CTL_SELECT] :
		sig_start ? pin_sel : ~cur_port_r;
	wire done = (state_r == UFO_ST_BUSY) &
		(swap_cnt_r == 8'(`UFO_SWAP_CYC - 1));

	// ****************************************************
	// Failover sequencer
	// ****************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= UFO_ST_IDLE;
			swap_cnt_r <= 8'h00;
			target_r <= 1'b0;
		end else begin
			unique case (state_r)
				UFO_ST_IDLE: begin
					swap_cnt_r <= 8'h00;
					if (start) begin
						state_r <= UFO_ST_BUSY;
						target_r <= start_target;
					end
				end
				UFO_ST_BUSY: begin
					swap_cnt_r <= swap_cnt_r + 8'h01;
					if (done) begin
						state_r <= UFO_ST_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************************
	// Strap capture, current port and control fields
	// ****************************************************
	// Written select is kept even outside failover mode; one written while busy is replaced by target_r at completion
	always_comb begin
		ctl_nxt = ctl_r;
		if (wr_ctl) begin
			ctl_nxt.select = wb_dat_i[`UFO_CTL_SELECT];
			ctl_nxt.sig_en = wb_dat_i[`UFO_CTL_SIG_EN];
			ctl_nxt.tim_en = wb_dat_i[`UFO_CTL_TIM_EN];
		end
		if (done) begin
			ctl_nxt.select = target_r;
		end
	end

	// Straps are caught on the first edge after release, not in reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			init_done_r <= 1'b0;
			mode_r <= 1'b0;
			cur_port_r <= 1'b0;
			ctl_r <= '0;
		end else if (!init_done_r) begin
			init_done_r <= 1'b1;
			mode_r <= strap_failover_mode;
			cur_port_r <= strap_upstream_port;
			ctl_r <= '{tim_en: strap_timer_enable,
				sig_en: strap_signal_enable,
				select: strap_upstream_port};
		end else begin
			ctl_r <= ctl_nxt;
			if (done) begin
				cur_port_r <= target_r;
			end
		end
	end

	// ****************************************************
	// Sticky change flags
	// ****************************************************
	// Hardware set wins over a write-one clear in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			done_flag_r <= 1'b0;
			started_flag_r <= 1'b0;
		end else begin
			done_flag_r <= done |
				(done_flag_r & ~(wr_sts & wb_dat_i[`UFO_STS_DONE]));
			started_flag_r <= start |
				(started_flag_r &
				~(wr_sts & wb_dat_i[`UFO_STS_STARTED]));
		end
	end

	// ****************************************************
	// Interrupt registers
	// ****************************************************
	wire [2:0] iclr = wr_iclr ? wb_dat_i[2:0] : 3'h0;
	assign irq_sts_nxt = ufo_evt_t'({wdog_fire, done, start} |
		(irq_sts_r & ~iclr));

	// Level output, registered from the next status
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_sts_r <= `UFO_IRQ_RST;
			irq_en_r <= `UFO_IRQ_RST;
			alt_en_r <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			irq_sts_r <= irq_sts_nxt;
			if (wr_ien) begin
				irq_en_r <= wb_dat_i[2:0];
			end
			if (wr_pin) begin
				alt_en_r <= wb_dat_i[`UFO_PIN_ALT];
			end
			irq_o <= |(irq_sts_nxt & (wr_ien ? wb_dat_i[2:0] : irq_en_r));
		end
	end

	// ****************************************************
	// Read mux and bus answer
	// ****************************************************
	// While busy the last written select shows, else the live port
	wire rd_select = idle ? cur_port_r : ctl_r.select;
	wire [31:0] rd_sts = {28'h000_0000, started_flag_r, done_flag_r,
		cur_port_r, mode_r};
	wire [31:0] rd_ctl = {29'h0000_0000, ctl_r.tim_en, ctl_r.sig_en,
		rd_select};
	// Unmapped and write-only words read as zero
	assign rdat = hit(wb_adr_i, `UFO_OFF_STATUS) ? rd_sts :
		hit(wb_adr_i, `UFO_OFF_CONTROL) ? rd_ctl :
		hit(wb_adr_i, `UFO_OFF_WDOG) ? wdog_r :
		hit(wb_adr_i, `UFO_OFF_IRQ_EN) ? {29'h0000_0000, irq_en_r} :
		hit(wb_adr_i, `UFO_OFF_IRQ_STS) ? {29'h0000_0000, irq_sts_r} :
		hit(wb_adr_i, `UFO_OFF_PIN_CFG) ? {31'h0000_0000, alt_en_r} :
		32'h0000_0000;

	// One-cycle ack, every address answered
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end else begin
			ack_r <= req;
			if (req) begin
				rdat_r <= rdat;
			end
		end
	end

	// Outputs come straight from flip-flops
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
	assign upstream_port_o = cur_port_r;
	assign failover_busy_o = state_r;

endmodule
`default_nettype wire

/* File: ufo_ctrl_properties.sv */
/* Port checker for the upstream failover controller, bound to ufo_ctrl.
   Assumes one core clock and the active-low rstn of that domain. */
`timescale 1ns/100ps
`default_nettype none
`include "ufo_defines.svh"
module ufo_ctrl_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire logic strap_failover_mode,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic upstream_port_o,
	input wire logic failover_busy_o
);
// ****************
// Properties
// ****************
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
// Bus request decode, taken only while ack is low
wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire sel_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == `UFO_OFF_CONTROL;
wire rd_sts = take && !wb_we_i && wb_adr_i == `UFO_OFF_STATUS;
wire rd_ctl = take && !wb_we_i && wb_adr_i == `UFO_OFF_CONTROL;
// Failover holds busy for exactly sixteen samples
sequence busy_16;
	failover_busy_o[*8] ##1 failover_busy_o[*8];
endsequence
ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
	else $error("ack wider than one cycle");
ack_next_a: assert property (take |=> wb_ack_o)
	else $error("ack missing after request");
busy_span_a: assert property ($rose(failover_busy_o) |->
	busy_16 ##1 !failover_busy_o) else $error("busy span wrong");
// Two edges of history, so the strap load after reset is not flagged
port_move_a: assert property ($past(rstn, 2) |->
	$changed(upstream_port_o) == $fell(failover_busy_o))
	else $error("port moved outside completion");
sw_start_a: assert property (sel_wr && !failover_busy_o &&
	strap_failover_mode && wb_dat_i[0] != upstream_port_o
	|=> $rose(failover_busy_o)) else $error("select write ignored");
mode_gate_a: assert property (!strap_failover_mode |->
	!failover_busy_o) else $error("failover without mode");
sts_read_a: assert property (wb_ack_o && $past(rd_sts) |->
	wb_dat_o[1:0] == {$past(upstream_port_o), $past(strap_failover_mode)}
	&& wb_dat_o[31:4] == 28'h000_0000) else $error("status read wrong");
ctl_read_a: assert property (wb_ack_o &&
	$past(rd_ctl && !failover_busy_o) |->
	wb_dat_o[0] == $past(upstream_port_o)) else $error("idle select wrong");
endmodule
bind ufo_ctrl ufo_ctrl_chk u_chk (.clk(clk), .rstn(rstn),
	.strap_failover_mode(strap_failover_mode), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .upstream_port_o(upstream_port_o),
	.failover_busy_o(failover_busy_o));
`default_nettype wire

/* File: ufo_ctrl_tb.sv */
/* Self-checking bench for the upstream failover controller.
   Assumes ufo_ctrl, its checker and the select source model. */
`timescale 1ns/100ps
`default_nettype none
`include "ufo_defines.svh"
module ufo_ctrl_tb;
logic clk, rstn, mode, sport, want, cyc, stb, we, ack, irq, port, busy, pin;
logic [11:0] adr;
logic [3:0] sel;
logic [31:0] dat, rdat, q, r;
logic ep, sen, ten;
int fail_count, checked, i;
integer seed;
// ****************
// Design and far side
// ****************
ufo_ctrl u_dut (.clk(clk), .rstn(rstn), .strap_failover_mode(mode),
	.strap_upstream_port(sport), .strap_signal_enable(sen),
	.strap_timer_enable(ten), .gpio_pin_in(pin), .wb_cyc_i(cyc),
	.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
	.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
	.upstream_port_o(port), .failover_busy_o(busy));
ufo_sel_drv u_sel (.clk(clk), .rstn(rstn), .want(want), .pin(pin));
// Core clock, 4 ns period
initial begin
	clk = 1'b0;
	forever #2 clk = ~clk;
end
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	checked++;
	if (got !== exp) begin
		fail_count++;
		$display("Error at %0t: got %h expected %h", $time, got, exp);
	end
endtask
// Expected status and control words, built from the field layout
function automatic logic [31:0] sts_word(input logic [1:0] fl,
	input logic p, input logic m);
	sts_word = {28'h000_0000, fl, p, m};
endfunction
function automatic logic [31:0] ctl_word(input logic t, input logic s,
	input logic p);
	ctl_word = {29'h0, t, s, p};
endfunction
// Classic cycle: hold until ack is sampled, then one idle cycle
task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
	int n;
	n = 0;
	cyc <= 1'b1;
	stb <= 1'b1;
	we <= w;
	adr <= a;
	dat <= d;
	do begin
		@(posedge clk);
		n++;
	end while (ack !== 1'b1);
	q = rdat;
	// Registered ack is seen at the second edge; a hang is the watchdog's
	chk(n, 32'h0000_0002);
	cyc <= 1'b0;
	stb <= 1'b0;
	@(posedge clk);
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] d);
	wb(1'b1, a, d);
endtask
task automatic rd(input logic [11:0] a, input logic [31:0] e);
	wb(1'b0, a, 32'h0000_0000);
	chk(q, e);
endtask
task automatic waitb(input logic v, input int lim);
	int n;
	n = 0;
	while (busy !== v && n < lim) begin
		@(posedge clk);
		n++;
	end
	chk({31'h0, busy}, {31'h0, v});
endtask
// A failover ends with the port toggled
task automatic fo(input int lim);
	waitb(1'b1, lim);
	waitb(1'b0, 30);
	ep = ~ep;
	chk({31'h0, port}, {31'h0, ep});
endtask
task automatic rst(input logic m);
	rstn <= 1'b0;
	mode <= m;
	sport <= 1'($random(seed));
	{sen, ten} <= 2'($random(seed));
	repeat (20) @(posedge clk);
	rstn <= 1'b1;
	repeat (2) @(posedge clk);
	ep = sport;
endtask
task tally_and_finish;
	$display("checks %0d mismatches %0d", checked, fail_count);
	if (fail_count == 0 && checked > 0) begin
		$display("TEST PASSED");
	end else begin
		$display("TEST FAILED");
	end
	$finish;
endtask
// Hang guard, far beyond the thousand or so cycles needed
initial begin
	#100000;
	fail_count++;
	$display("Error at %0t: timeout", $time);
	tally_and_finish;
end
// ****************
// Scenarios
// ****************
initial begin
	seed = 64810;
	fail_count = 0;
	checked = 0;
	{rstn, mode, sport, sen, ten, want, cyc, stb, we} = 9'h000;
	adr = 12'h000;
	sel = 4'hf;
	dat = 32'h0000_0000;
	rst(1'b1);
	rd(`UFO_OFF_STATUS, sts_word(2'b00, ep, 1'b1));
	rd(`UFO_OFF_CONTROL, ctl_word(ten, sen, ep));
	rd(`UFO_OFF_WDOG, `UFO_WDOG_RST);
	rd(12'h4f0, 32'h0000_0000);
	$display("reset test done");
	for (i = 0; i < 8; i++) begin
		r = $random(seed);
		wr(`UFO_OFF_CONTROL, {31'h0, r[0]});
		if (r[0] !== ep) begin
			rd(`UFO_OFF_CONTROL, ctl_word(1'b0, 1'b0, r[0]));
			fo(4);
			rd(`UFO_OFF_STATUS, sts_word(2'b11, ep, 1'b1));
			wr(`UFO_OFF_STATUS, 32'h0000_000c);
		end
		rd(`UFO_OFF_STATUS, {30'h0, ep, 1'b1});
	end
	$display("software test done");
	// Pin matches the port first, so enabling it starts nothing
	want <= ep;
	wr(`UFO_OFF_PIN_CFG, 32'h0000_0001);
	wr(`UFO_OFF_CONTROL, {30'h0, 1'b1, ep});
	want <= ~ep;
	fo(10);
	rd(`UFO_OFF_CONTROL, ctl_word(1'b0, 1'b1, ep));
	$display("signal test done");
	wr(`UFO_OFF_IRQ_EN, 32'h0000_0004);
	wr(`UFO_OFF_CONTROL, {29'h0, 2'b10, ep});
	wr(`UFO_OFF_WDOG, 32'h0000_0002);
	fo(600);
	chk({31'h0, irq}, 32'h0000_0001);
	rd(`UFO_OFF_WDOG, 32'h0000_0000);
	rd(`UFO_OFF_IRQ_STS, 32'h0000_0007);
	wr(`UFO_OFF_IRQ_EN, 32'h0000_0000);
	chk({31'h0, irq}, 32'h0000_0000);
	wr(`UFO_OFF_IRQ_CLR, 32'h0000_0007);
	rd(`UFO_OFF_IRQ_STS, 32'h0000_0000);
	// Expiry with the timer enable clear must leave the port alone
	wr(`UFO_OFF_CONTROL, {31'h0, ep});
	wr(`UFO_OFF_WDOG, 32'h0000_0001);
	repeat (300) @(posedge clk);
	chk({31'h0, port}, {31'h0, ep});
	rd(`UFO_OFF_IRQ_STS, 32'h0000_0004);
	$display("timer test done");
	rst(1'b0);
	wr(`UFO_OFF_CONTROL, {31'h0, ~ep});
	repeat (20) @(posedge clk);
	chk({31'h0, port}, {31'h0, ep});
	rd(`UFO_OFF_STATUS, sts_word(2'b00, ep, 1'b0));
	$display("mode test done");
	tally_and_finish;
end
endmodule
`default_nettype wire

/* File: ufo_defines.svh */
/*
 * Offsets, field positions, reset values and timing counts for the
 * upstream port failover controller.
 * Assumes a 250 MHz core clock and byte addresses on the register bus.
 */
`ifndef UFO_DEFINES_SVH
`define UFO_DEFINES_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define UFO_OFF_STATUS 12'h470
`define UFO_OFF_CONTROL 12'h474
`define UFO_OFF_WDOG 12'h478
`define UFO_OFF_IRQ_EN 12'h480
`define UFO_OFF_IRQ_CLR 12'h484
`define UFO_OFF_IRQ_STS 12'h488
`define UFO_OFF_PIN_CFG 12'h48C

// ****************************************************
// Field positions
// ****************************************************
`define UFO_STS_ENABLED 0
`define UFO_STS_CUR_PORT 1
`define UFO_STS_DONE 2
`define UFO_STS_STARTED 3
`define UFO_CTL_SELECT 0
`define UFO_CTL_SIG_EN 1
`define UFO_CTL_TIM_EN 2
`define UFO_IRQ_STARTED 0
`define UFO_IRQ_DONE 1
`define UFO_IRQ_WDOG 2
`define UFO_PIN_ALT 0

// ****************************************************
// Reset values and timing
// ****************************************************
`define UFO_WDOG_RST 32'h0000_0000
`define UFO_IRQ_RST 3'h0
`define UFO_CLK_NS 4
`define UFO_TICK_NS 1000
`define UFO_TICK_CYC ((`UFO_TICK_NS + `UFO_CLK_NS - 1) / `UFO_CLK_NS)
`define UFO_SWAP_CYC 16

`endif

/* File: ufo_pkg.sv */
/*
 * Types shared by the upstream port failover controller.
 * Assumes nothing of its surroundings.
 */
package ufo_pkg;

	// Failover sequencer states
	typedef enum logic [0:0] {
		UFO_ST_IDLE = 1'b0,
		UFO_ST_BUSY = 1'b1
	} ufo_state_t;

	// Control fields held together
	typedef struct packed {
		logic tim_en;
		logic sig_en;
		logic select;
	} ufo_ctl_t;

	// Events that feed the interrupt status
	typedef struct packed {
		logic wdog;
		logic done;
		logic started;
	} ufo_evt_t;

endpackage

/* File: ufo_sel_drv.sv */
/* External upstream select source driving the GPIO pin level.
   Assumes the bench names the wanted level; clk is the core clock. */
`timescale 1ns/100ps
`default_nettype none
module ufo_sel_drv (
	input wire logic clk,
	input wire logic rstn,
	input wire logic want,
	output logic pin
);
// Registered, since the controller takes the pin as synchronous
always_ff @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		pin <= 1'b0;
	end else begin
		pin <= want;
	end
end
endmodule
`default_nettype wire
